/* hdl/scc_params.svh */
// Offsets, field positions, reset values and timing counts for clock switching
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SCC_OFF_REQUEST   8'h00
`define SCC_OFF_CURRENT   8'h04
`define SCC_OFF_CONTROL   8'h08
`define SCC_OFF_IRQ_STAT  8'h0c
`define SCC_OFF_IRQ_CLR   8'h10
`define SCC_OFF_IRQ_EN    8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCC_SRC_LSB       4
`define SCC_SRC_MSB       6
`define SCC_DIV_LSB       0
`define SCC_DIV_MSB       3
`define SCC_HOLD_BIT      7
`define SCC_DONE_BIT      4
`define SCC_NSR_BIT       3
`define SCC_IRQ_EVT_BIT   0
`define SCC_IRQ_DONE_BIT  1

// ----------------------------------------------------------------------
// Source and divider codes, reset values
// ----------------------------------------------------------------------
`define SCC_SRC_EXT       3'h7
`define SCC_SRC_HF        3'h6
`define SCC_SRC_LF        3'h5
`define SCC_SRC_EXT_PLL   3'h2
`define SCC_SRC_HF_PLL    3'h1
`define SCC_DIV_HF_RST    4'h2
`define SCC_DIV_RST       4'h0
`define SCC_DIV_MAX       4'h9
`define SCC_CONTROL_RST   8'h00

// ----------------------------------------------------------------------
// Timing: clock held still around the mux change
// ----------------------------------------------------------------------
`define SCC_CLK_NS        5
`define SCC_GATE_NS       10
`define SCC_GATE_CYC      ((`SCC_GATE_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)

`endif

/* hdl/scc_pkg.sv */
// Types shared by the clock switch control
package scc_pkg;

    typedef struct packed {
        logic [2:0] src;
        logic [3:0] div;
    } scc_sel_t;

    typedef enum logic [1:0] {
        SCC_IDLE    = 2'b00,
        SCC_PENDING = 2'b01,
        SCC_HELD    = 2'b10,
        SCC_GATE    = 2'b11
    } scc_state_t;

endpackage : scc_pkg

/* hdl/scc_top.sv */
// System clock source and divider switch control with Avalon-MM registers
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps

`include "scc_params.svh"

module scc_top
    import scc_pkg::*;
#(
    parameter int GATE_CYCLES = `SCC_GATE_CYC
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    // Avalon-MM slave
    input  wire logic [7:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic [31:0]      AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    // Fuses and core state
    input  wire logic [2:0]  RESET_SOURCE_SETTING_I,
    input  wire logic        SWITCH_PERMIT_I,
    input  wire logic        SLEEP_I,
    // Oscillator ready: ext, hf, lf, ext_pll, hf_pll
    input  wire logic [4:0]  OSC_READY_I,
    // Clock mux control and interrupt
    output scc_sel_t         SYS_SEL_O,
    output logic             SYS_CLK_RUN_O,
    output logic             IRQ_O
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // source code map
    function automatic logic [2:0] src_index(input logic [2:0] s);
        unique case (s)
            `SCC_SRC_EXT:     src_index = 3'h0;
            `SCC_SRC_HF:      src_index = 3'h1;
            `SCC_SRC_LF:      src_index = 3'h2;
            `SCC_SRC_EXT_PLL: src_index = 3'h3;
            `SCC_SRC_HF_PLL:  src_index = 3'h4;
            default:          src_index = 3'h7;
        endcase
    endfunction : src_index

    function automatic logic src_valid(input logic [2:0] s);
        src_valid = (src_index(s) != 3'h7);
    endfunction : src_valid

    function automatic logic [3:0] div_reset(input logic [2:0] s);
        div_reset = (s == `SCC_SRC_HF) ? `SCC_DIV_HF_RST : `SCC_DIV_RST;
    endfunction : div_reset

    // ------------------------------------------------------------------
    // Ready synchronisers
    // ------------------------------------------------------------------
    logic [4:0] rdy_s1_reg;
    logic [4:0] rdy_s2_reg;
    logic [4:0] rdy_s3_reg;
    logic [4:0] rdy_reg;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdy_s1_reg <= 5'h00;
            rdy_s2_reg <= 5'h00;
            rdy_s3_reg <= 5'h00;
            rdy_reg    <= 5'h00;
        end else begin
            rdy_s1_reg <= OSC_READY_I;
            rdy_s2_reg <= rdy_s1_reg;
            rdy_s3_reg <= rdy_s2_reg;
            rdy_reg    <= (rdy_s2_reg & rdy_s3_reg) |
                          (rdy_reg & (rdy_s2_reg | rdy_s3_reg));
        end
    end

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    logic       wait_reg;
    logic       req;
    logic       acc;
    logic       wr_acc;
    logic [7:0] wb;

    assign req    = AVS_READ_I | AVS_WRITE_I;
    assign acc    = req & ~wait_reg;
    assign wr_acc = acc & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
    assign wb     = AVS_WRITEDATA_I[7:0];

    // One wait cycle, then the access completes
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~(req & wait_reg);
        end
    end
    assign AVS_WAITREQUEST_O = wait_reg;

    // ------------------------------------------------------------------
    // Request, active selection and init
    // ------------------------------------------------------------------
    logic       init_reg;
    scc_sel_t   req_reg;
    scc_sel_t   act_reg;
    logic       hold_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_en_reg;
    logic [1:0] w1c;
    scc_state_t state_reg;
    logic [7:0] gate_cnt_reg;
    logic       sel_rdy;
    logic       nsr;
    logic       done;
    logic       evt_ready;
    logic       evt_done;
    logic [2:0] fuse_src;

    assign fuse_src = src_valid(RESET_SOURCE_SETTING_I) ?
                      RESET_SOURCE_SETTING_I : `SCC_SRC_HF;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            init_reg <= 1'b0;
        end else begin
            init_reg <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            req_reg <= '0;
        end else if (!init_reg) begin
            req_reg.src <= fuse_src;
            req_reg.div <= div_reset(fuse_src);
        end else if (wr_acc && AVS_ADDRESS_I == `SCC_OFF_REQUEST &&
                     SWITCH_PERMIT_I &&
                     src_valid(wb[`SCC_SRC_MSB:`SCC_SRC_LSB])) begin
            req_reg.src <= wb[`SCC_SRC_MSB:`SCC_SRC_LSB];
            req_reg.div <= wb[`SCC_DIV_MSB:`SCC_DIV_LSB];
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            act_reg <= '0;
        end else if (!init_reg) begin
            act_reg.src <= fuse_src;
            act_reg.div <= div_reset(fuse_src);
        end else if (state_reg == SCC_GATE && gate_cnt_reg == 8'h00) begin
            act_reg <= req_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hold_reg <= 1'(`SCC_CONTROL_RST >> `SCC_HOLD_BIT);
        end else if (wr_acc && AVS_ADDRESS_I == `SCC_OFF_CONTROL) begin
            hold_reg <= wb[`SCC_HOLD_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------------
    assign sel_rdy   = rdy_reg[src_index(req_reg.src)];
    assign nsr       = (state_reg == SCC_HELD && sel_rdy && req_reg != act_reg)
                       || state_reg == SCC_GATE;
    assign done      = init_reg && state_reg == SCC_IDLE && req_reg == act_reg;
    assign evt_ready = state_reg == SCC_PENDING && sel_rdy && !SLEEP_I &&
                       req_reg != act_reg;
    assign evt_done  = state_reg == SCC_GATE && gate_cnt_reg == 8'h00;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg    <= SCC_IDLE;
            gate_cnt_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                SCC_IDLE: begin
                    if (init_reg && req_reg != act_reg) begin
                        state_reg <= SCC_PENDING;
                    end
                end
                SCC_PENDING: begin
                    if (req_reg == act_reg) begin
                        state_reg <= SCC_IDLE;
                    end else if (evt_ready) begin
                        state_reg    <= hold_reg ? SCC_HELD : SCC_GATE;
                        gate_cnt_reg <= 8'(GATE_CYCLES - 1);
                    end
                end
                SCC_HELD: begin
                    if (req_reg == act_reg) begin
                        state_reg <= SCC_IDLE;
                    end else if (!sel_rdy) begin
                        state_reg <= SCC_PENDING;
                    end else if (!hold_reg && !SLEEP_I) begin
                        state_reg <= SCC_GATE;
                    end
                end
                SCC_GATE: begin
                    if (gate_cnt_reg == 8'h00) begin
                        state_reg <= SCC_IDLE;
                    end else begin
                        gate_cnt_reg <= gate_cnt_reg - 8'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock mux outputs
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SYS_CLK_RUN_O <= 1'b0;
        end else begin
            SYS_CLK_RUN_O <= init_reg && !(state_reg == SCC_GATE) &&
                             !(evt_ready && !hold_reg) &&
                             !(state_reg == SCC_HELD && !hold_reg);
        end
    end
    assign SYS_SEL_O = act_reg;

    // ------------------------------------------------------------------
    // Interrupts: sticky status, enable, write-one clear
    // ------------------------------------------------------------------
    assign w1c = {2{wr_acc && AVS_ADDRESS_I == `SCC_OFF_IRQ_CLR}} & wb[1:0];

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~w1c) | {evt_done, evt_ready};
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_en_reg <= 2'h0;
        end else if (wr_acc && AVS_ADDRESS_I == `SCC_OFF_IRQ_EN) begin
            irq_en_reg <= wb[1:0];
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rd_next;

    always_comb begin
        rd_next = 8'h00;
        unique case (AVS_ADDRESS_I)
            `SCC_OFF_REQUEST:  rd_next = {1'b0, req_reg.src, req_reg.div};
            `SCC_OFF_CURRENT:  rd_next = {1'b0, act_reg.src, act_reg.div};
            `SCC_OFF_CONTROL:  rd_next = {hold_reg, 2'b00, done, nsr, 3'b000};
            `SCC_OFF_IRQ_STAT: rd_next = {6'h00, irq_stat_reg};
            `SCC_OFF_IRQ_EN:   rd_next = {6'h00, irq_en_reg};
            default:           rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (AVS_READ_I && wait_reg) begin
            AVS_READDATA_O <= {24'h00_0000, rd_next};
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_reserved_write_drop:
    assert property (wr_acc && AVS_ADDRESS_I == `SCC_OFF_REQUEST &&
                     !src_valid(wb[6:4]) && init_reg
                     |=> $stable(req_reg))
        else $error("reserved source write changed request");
    a_permit_lock:
    assert property (!SWITCH_PERMIT_I && init_reg |=> $stable(req_reg))
        else $error("request changed without permit");
    a_reset_div_load:
    assert property ($rose(init_reg) |-> req_reg.div == div_reset(req_reg.src))
        else $error("divider reset value wrong");
    a_active_init_same:
    assert property ($rose(init_reg) |-> act_reg == req_reg)
        else $error("active differs from request at reset");
    a_hold_suspends:
    assert property (evt_ready && hold_reg |=> state_reg == SCC_HELD
                     ##0 $stable(act_reg))
        else $error("hold did not suspend switch");
    a_switch_completes:
    assert property (evt_ready && !hold_reg |=> state_reg == SCC_GATE
                     ##[0:8] evt_done)
        else $error("switch did not complete");
    a_ready_flag_state:
    assert property (nsr |-> req_reg != act_reg || state_reg == SCC_GATE)
        else $error("ready flag set with nothing pending");
    a_switch_updates:
    assert property (evt_done |=> act_reg == $past(req_reg) && !nsr)
        else $error("switch did not update active");
    a_event_flag_set:
    assert property (evt_ready |=> irq_stat_reg[`SCC_IRQ_EVT_BIT])
        else $error("event flag not set");
    a_sleep_blocks:
    assert property (SLEEP_I && state_reg == SCC_PENDING
                     |=> state_reg != SCC_GATE)
        else $error("switch started during sleep");
    a_clock_gated:
    assert property (state_reg == SCC_GATE |=> !SYS_CLK_RUN_O)
        else $error("clock ran while mux changed");

    c_held_switch:   cover property (state_reg == SCC_HELD ##[1:20] evt_done);
    c_direct_switch: cover property (evt_ready && !hold_reg);
    c_abandon:       cover property (state_reg == SCC_HELD ##1
                                     state_reg == SCC_IDLE);
    c_irq:           cover property ($rose(IRQ_O));

endmodule : scc_top

/* verif/scc_osc_model.sv */
// Behavioural oscillator bank: each source turns ready some cycles after enable
`timescale 1ns/1ps

module scc_osc_model (
    // Clock and stimulus
    input  wire logic       clk_i,
    input  wire logic [4:0] on_i,
    input  wire logic       slow_i,
    // Ready levels
    output logic      [4:0] ready_o = 5'h00
);
    logic [5:0] cnt [5] = '{default: 6'h00};

    // ------------------------------------------------------------------
    // Start-up delay, prompt or slow; ready drops at once when disabled
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        for (int i = 0; i < 5; i++) begin
            if (!on_i[i]) begin
                cnt[i]     <= 6'h00;
                ready_o[i] <= 1'b0;
            end else if (cnt[i] == (slow_i ? 6'h28 : 6'h02)) begin
                ready_o[i] <= 1'b1;
            end else begin
                cnt[i] <= cnt[i] + 6'h01;
            end
        end
    end
endmodule : scc_osc_model

/* verif/testbench.sv */
// Self-checking bench for the clock switch control
`timescale 1ns/1ps

module testbench;
    import scc_pkg::*;
    logic        CORE_CLK_I = 1'b0;
    logic        RST_N_I = 1'b0;
    logic [7:0]  AVS_ADDRESS_I = 8'h00;
    logic        AVS_READ_I = 1'b0;
    logic        AVS_WRITE_I = 1'b0;
    logic [31:0] AVS_WRITEDATA_I = 32'h0;
    logic [31:0] AVS_READDATA_O;
    logic        AVS_WAITREQUEST_O;
    logic [2:0]  RESET_SOURCE_SETTING_I = 3'h6;
    logic        SWITCH_PERMIT_I = 1'b1;
    logic        SLEEP_I = 1'b0;
    logic [4:0]  OSC_READY_I;
    logic [4:0]  osc_on = 5'h1f;
    logic        slow = 1'b0;
    scc_sel_t    SYS_SEL_O;
    logic        SYS_CLK_RUN_O;
    logic        IRQ_O;
    int          mismatches = 0;
    int          checks_done = 0;
    logic [31:0] q_exp [$];
    logic [2:0]  srcs [5] = '{3'h7, 3'h6, 3'h5, 3'h2, 3'h1};
    logic [6:0]  sel;

    always #2.5 CORE_CLK_I = ~CORE_CLK_I;

    scc_top #(.GATE_CYCLES(2)) scc_top_i (
        .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
        .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
        .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(AVS_READDATA_O),
        .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
        .RESET_SOURCE_SETTING_I(RESET_SOURCE_SETTING_I),
        .SWITCH_PERMIT_I(SWITCH_PERMIT_I), .SLEEP_I(SLEEP_I),
        .OSC_READY_I(OSC_READY_I), .SYS_SEL_O(SYS_SEL_O),
        .SYS_CLK_RUN_O(SYS_CLK_RUN_O), .IRQ_O(IRQ_O));

    scc_osc_model scc_osc_model_i (.clk_i(CORE_CLK_I), .on_i(osc_on),
        .slow_i(slow), .ready_o(OSC_READY_I));

    // ------------------------------------------------------------------
    // Comparison, verdict and bus tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(posedge CORE_CLK_I);
        AVS_ADDRESS_I   <= a;
        AVS_WRITE_I     <= w;
        AVS_READ_I      <= !w;
        AVS_WRITEDATA_I <= {24'h0, d};
        do begin
            @(posedge CORE_CLK_I);
        end while (AVS_WAITREQUEST_O !== 1'b0);
        AVS_READ_I  <= 1'b0;
        AVS_WRITE_I <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q_exp.push_back(e);
        bus(a, 1'b0, 8'h00);
    endtask : rd

    task automatic do_reset(input logic [2:0] fuse);
        RST_N_I <= 1'b0;
        RESET_SOURCE_SETTING_I <= fuse;
        repeat (16) @(posedge CORE_CLK_I);
        RST_N_I <= 1'b1;
        repeat (2) @(posedge CORE_CLK_I);
    endtask : do_reset

    // Waits for the mux to take a selection, noting a stopped clock
    task automatic wait_sel(input logic [6:0] e);
        int   n;
        logic low;
        n = 0;
        low = 1'b0;
        while (SYS_SEL_O !== e && n < 300) begin
            @(posedge CORE_CLK_I);
            if (SYS_CLK_RUN_O === 1'b0) low = 1'b1;
            n++;
        end
        repeat (3) @(posedge CORE_CLK_I);
        check({25'h0, SYS_SEL_O}, {25'h0, e});
        check({31'h0, low}, 32'h1);
    endtask : wait_sel

    // ------------------------------------------------------------------
    // Read monitor: oldest expectation against each completed read
    // ------------------------------------------------------------------
    always @(posedge CORE_CLK_I) begin
        if (AVS_READ_I && AVS_WAITREQUEST_O === 1'b0 && q_exp.size() > 0)
            check(AVS_READDATA_O, q_exp.pop_front());
    end

    initial begin
        #400us;
        mismatches++;
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hd1c0));
        // Fuse loads request and active; a reserved fuse maps to 110
        for (int i = 0; i < 6; i++) begin
            do_reset(i < 5 ? srcs[i] : 3'h4);
            sel = (i == 1 || i == 5) ? 7'h62 : {srcs[i], 4'h0};
            rd(8'h00, {25'h0, sel});
            rd(8'h04, {25'h0, sel});
            rd(8'h08, 32'h10);
            rd(8'h0c, 32'h0);
        end
        rd(8'h1c, 32'h0);
        $display("test reset_values done");
        // Reserved source writes and writes without permit are dropped
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, {1'b0, i == 0 ? 3'h4 : (i == 1 ? 3'h3 : 3'h0), 4'h5});
            rd(8'h00, 32'h62);
        end
        SWITCH_PERMIT_I <= 1'b0;
        wr(8'h00, 8'h75);
        rd(8'h00, 32'h62);
        SWITCH_PERMIT_I <= 1'b1;
        $display("test refused_writes done");
        // Every valid source with a random divider, free switching
        wr(8'h14, 8'h03);
        for (int i = 0; i < 5; i++) begin
            slow   <= (i == 2);
            osc_on <= (i == 2) ? 5'h1b : 5'h1f;
            sel = {srcs[i], 4'($urandom_range(9, 0))};
            wr(8'h10, 8'h03);
            osc_on <= 5'h1f;
            wr(8'h00, {1'b0, sel});
            wait_sel(sel);
            rd(8'h04, {25'h0, sel});
            rd(8'h08, 32'h10);
            rd(8'h0c, 32'h03);
            check({31'h0, IRQ_O}, 32'h1);
        end
        slow   <= 1'b0;
        osc_on <= 5'h1e;
        $display("test switch_sources done");
        // Held switch: event raised, old clock kept, then released
        wr(8'h10, 8'h03);
        wr(8'h08, 8'h80);
        wr(8'h00, 8'h73);
        rd(8'h08, 32'h80);
        osc_on <= 5'h1f;
        repeat (30) @(posedge CORE_CLK_I);
        rd(8'h08, 32'h88);
        rd(8'h04, {25'h0, sel});
        rd(8'h0c, 32'h01);
        check({31'h0, IRQ_O}, 32'h1);
        wr(8'h14, 8'h00);
        repeat (3) @(posedge CORE_CLK_I);
        check({31'h0, IRQ_O}, 32'h0);
        wr(8'h10, 8'h01);
        rd(8'h0c, 32'h00);
        wr(8'h14, 8'h03);
        wr(8'h08, 8'h00);
        wait_sel(7'h73);
        rd(8'h08, 32'h10);
        $display("test hold_release done");
        // Held switch abandoned by copying active back into request
        wr(8'h08, 8'h80);
        wr(8'h00, 8'h54);
        repeat (30) @(posedge CORE_CLK_I);
        rd(8'h08, 32'h88);
        wr(8'h00, 8'h73);
        repeat (5) @(posedge CORE_CLK_I);
        rd(8'h08, 32'h90);
        check({25'h0, SYS_SEL_O}, 32'h73);
        wr(8'h08, 8'h00);
        $display("test hold_abandon done");
        // Sleep blocks a pending switch until it ends
        SLEEP_I <= 1'b1;
        wr(8'h00, 8'h69);
        repeat (40) @(posedge CORE_CLK_I);
        check({25'h0, SYS_SEL_O}, 32'h73);
        rd(8'h08, 32'h00);
        SLEEP_I <= 1'b0;
        wait_sel(7'h69);
        $display("test sleep_block done");
        repeat (4) @(posedge CORE_CLK_I);
        results();
    end
endmodule : testbench
